// ---- src/nvm_cmd_defines.svh ----
// Register indices, field positions, reset values and command codes of the command front end
`ifndef NVM_CMD_DEFINES_SVH
`define NVM_CMD_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_PARAM_INDEX     6'h02
`define IDX_ERR_CONFIG      6'h04
`define IDX_FLASH_STATUS    6'h06
`define IDX_ERR_STATUS      6'h07
`define IDX_PARAM_WORD      6'h0a

// ----------------------------------------------------------------------------
// Flash status field positions
// ----------------------------------------------------------------------------
`define STAT_CMD_DONE       7
`define STAT_ACC_ERR        5
`define STAT_PROT_VIOL      4
`define STAT_BUSY           3
`define STAT_VERIFY_HI      1
`define STAT_VERIFY_LO      0

// ----------------------------------------------------------------------------
// Error config and error status field positions
// ----------------------------------------------------------------------------
`define ERR_CHANGE_STATE    3
`define ERR_SECTOR_FORMAT   2
`define ERR_DOUBLE_FAULT    1
`define ERR_SINGLE_FAULT    0

// ----------------------------------------------------------------------------
// Command codes, parameter slots and query defaults
// ----------------------------------------------------------------------------
`define CMD_DISABLE_EMUL    8'h14
`define CMD_EMUL_QUERY      8'h15
`define PIDX_CMD            3'h0
`define PIDX_USER_PART      3'h1
`define PIDX_BUF_PART       3'h2
`define PIDX_ERASE_CNT      3'h3
`define PIDX_SECTOR_CNT     3'h4
`define PIDX_FIRST_UNIMPL   3'h6
`define QUERY_NO_PART       16'hffff
`define QUERY_NO_COUNT      8'h00
`define PARAM_RESET         16'h0000

`endif

// ---- src/nvm_cmd_pkg.sv ----
// Types shared by the command front end
package nvm_cmd_pkg;
  // Sequencer states, Gray along idle to either operation and back
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HALT  = 2'b01,
    ST_QUERY = 2'b10
  } seq_state_t;
endpackage : nvm_cmd_pkg

// ---- src/phrase_fault_detect.sv ----
// Single-correct, double-detect check over one 64-bit read phrase
`timescale 1ns/1ps
module phrase_fault_detect #(
  parameter int DW = 64
) (
  input  wire logic [DW-1:0] data_in,     // Raw phrase from the array
  input  wire logic [7:0]    check_in,    // Stored check bits, bit 7 is overall parity
  output logic      [DW-1:0] data_out,    // Corrected phrase
  output logic               single_out,  // One bit was wrong and was fixed
  output logic               double_out   // Two bits wrong, not correctable
);
  // Column code per data bit; none has weight one, so check-bit hits never alias
  function automatic logic [6:0] code_of(input int i);
    if (i == 0) begin
      return 7'h03;
    end
    return {1'b1, i[5:0]};
  endfunction : code_of

  logic [6:0] calc;
  logic [6:0] syndrome;
  logic       parity_bad;

  // Syndrome bits, one XOR tree per check bit
  for (genvar j = 0; j < 7; j++) begin : g_syn
    logic [DW-1:0] mask;
    for (genvar i = 0; i < DW; i++) begin : g_mask
      localparam logic [6:0] COL = code_of(i);
      assign mask[i] = COL[j];
    end
    assign calc[j] = ^(data_in & mask);
  end

  assign syndrome   = calc ^ check_in[6:0];
  assign parity_bad = ^{data_in, check_in};
  assign single_out = parity_bad;
  assign double_out = !parity_bad && (syndrome != 7'h00);

  // Flip only the bit whose code matches an odd-parity syndrome
  for (genvar i = 0; i < DW; i++) begin : g_fix
    assign data_out[i] = data_in[i] ^ (parity_bad && (syndrome == code_of(i)));
  end
endmodule : phrase_fault_detect

// ---- src/nvm_cmd_launch.sv ----
// Command launch, parameter array, status and error reporting of the flash controller
// Operation
// - Code 0x14 halts emulation at a safe point, tags kept, then sets done flag.
// - Disable command with parameter index not zero at launch raises access error.
// - Launch while a load-data-field sequence is active raises access error.
// - Disable without prior partitioning raises access error; other status untouched.
// - Code 0x15 writes partition sizes, erase count and sector counts to slots 1-4.
// - Query sets done flag only once all results sit in the array.
// - Unpartitioned query returns all-ones sizes and count, zero sector counts.
// - Config bit 3 gates the change-state error interrupt.
// - Config bit 2 gates the sector-format error interrupt.
// - Config bit 1 gates the double-fault interrupt.
// - Config bit 0 gates the single-fault interrupt.
// - Done, access error, protection bits writable; busy, verify read-only; rest zero.
// - Double fault during reset sequence may alter status reset value.
// - Software loads parameters, writes one to done flag; device clears it.
// - Parameter fields locked from launch until done flag returns.
// - Slots 6 and 7 ignore writes and read as zero.
// - Slot 0 holds command code high, zero plus address bits 22:16 low.
// - Reads correct single and detect double faults per 64-bit phrase.
`timescale 1ns/1ps
`include "nvm_cmd_defines.svh"
module nvm_cmd_launch #(
  parameter int PW = 64                       // Read phrase width
) (
  input  wire logic          clk_in,          // Bus clock, 200 MHz
  input  wire logic          rstn_in,         // Async reset, active low
  // Wishbone classic slave
  input  wire logic          wb_cyc_in,       // Cycle
  input  wire logic          wb_stb_in,       // Strobe
  input  wire logic          wb_we_in,        // Write enable
  input  wire logic [7:0]    wb_adr_in,       // Byte address
  input  wire logic [3:0]    wb_sel_in,       // Byte lanes
  input  wire logic [31:0]   wb_dat_in,       // Write data
  output logic      [31:0]   wb_dat_out,      // Read data
  output logic               wb_ack_out,      // Acknowledge
  // Emulation engine and partition state
  input  wire logic          load_seq_in,     // Load-data-field sequence active
  input  wire logic          partitioned_in,  // A partitioning command has run
  output logic               halt_req_out,    // Ask engine to stop at safe point
  input  wire logic          halt_ack_in,     // Engine stopped, tags intact
  input  wire logic [15:0]   user_part_in,    // User partition sectors
  input  wire logic [15:0]   buf_part_in,     // Buffer partition sectors
  input  wire logic [15:0]   erase_cnt_in,    // Sector erase count
  input  wire logic [7:0]    dead_cnt_in,     // Dead sector count
  input  wire logic [7:0]    ready_cnt_in,    // Ready sector count
  input  wire logic          change_err_in,   // Change-state error pulse
  input  wire logic          format_err_in,   // Sector-format error pulse
  input  wire logic          prot_viol_in,    // Protection violation pulse
  input  wire logic          reset_dfault_in, // Double fault seen in reset sequence
  // Array read path
  input  wire logic          rd_valid_in,     // Phrase valid
  input  wire logic [PW-1:0] rd_data_in,      // Raw phrase
  input  wire logic [7:0]    rd_check_in,     // Check bits
  output logic               rd_valid_out,    // Corrected phrase valid
  output logic      [PW-1:0] rd_data_out,     // Corrected phrase
  // Command hand-off and interrupt
  output logic      [7:0]    cmd_code_out,    // Code of running command
  output logic               error_irq_out    // Gated error interrupt
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  nvm_cmd_pkg::seq_state_t state_r;
  logic [15:0] param_mem [0:5];
  logic [2:0]  param_idx_r;
  logic        cmd_done_r;
  logic        acc_err_r;
  logic        prot_viol_r;
  logic [1:0]  verify_r;
  logic [3:0]  err_cfg_r;
  logic [3:0]  err_flag_r;
  logic [7:0]  cmd_r;
  logic [2:0]  qcnt_r;
  logic        init_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic        irq_r;
  logic        rdv_r;
  logic [PW-1:0] rdd_r;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire        acc      = wb_cyc_in && wb_stb_in && !ack_r;
  wire [5:0]  widx     = wb_adr_in[7:2];
  wire        wr       = acc && wb_we_in;
  wire        wr_pidx  = wr && (widx == `IDX_PARAM_INDEX) && wb_sel_in[0];
  wire        wr_cfg   = wr && (widx == `IDX_ERR_CONFIG) && wb_sel_in[0];
  wire        wr_stat  = wr && (widx == `IDX_FLASH_STATUS) && wb_sel_in[0];
  wire        wr_estat = wr && (widx == `IDX_ERR_STATUS) && wb_sel_in[0];
  wire        wr_param = wr && (widx == `IDX_PARAM_WORD);
  wire        idx_impl = (param_idx_r < `PIDX_FIRST_UNIMPL);
  wire        busy     = (state_r != nvm_cmd_pkg::ST_IDLE);

  // Launch and its checks; a write of one with errors still pending is ignored
  wire        launch   = wr_stat && wb_dat_in[`STAT_CMD_DONE] && cmd_done_r
                         && !acc_err_r && !prot_viol_r;
  wire [7:0]  code     = param_mem[0][15:8];
  wire        known    = (code == `CMD_DISABLE_EMUL) || (code == `CMD_EMUL_QUERY);
  wire        bad_idx  = (param_idx_r != `PIDX_CMD);
  wire        no_part  = (code == `CMD_DISABLE_EMUL) && !partitioned_in;
  wire        reject   = load_seq_in || bad_idx || no_part || !known;
  wire        accept   = launch && !reject;

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  wire [7:0]  stat_rd  = {cmd_done_r, 1'b0, acc_err_r, prot_viol_r,
                          busy, 1'b0, verify_r};
  wire [15:0] param_rd = idx_impl ? param_mem[param_idx_r] : 16'h0000;
  wire [31:0] rd_mux   =
      (widx == `IDX_PARAM_INDEX)  ? {29'h0, param_idx_r} :
      (widx == `IDX_ERR_CONFIG)   ? {28'h0, err_cfg_r} :
      (widx == `IDX_FLASH_STATUS) ? {24'h0, stat_rd} :
      (widx == `IDX_ERR_STATUS)   ? {28'h0, err_flag_r} :
      (widx == `IDX_PARAM_WORD)   ? {16'h0, param_rd} : 32'h0;

  // Query result for the slot being filled
  wire        part_ok  = partitioned_in;
  wire [15:0] q_val    =
      (qcnt_r == `PIDX_USER_PART) ? (part_ok ? user_part_in : `QUERY_NO_PART) :
      (qcnt_r == `PIDX_BUF_PART)  ? (part_ok ? buf_part_in  : `QUERY_NO_PART) :
      (qcnt_r == `PIDX_ERASE_CNT) ? (part_ok ? erase_cnt_in : `QUERY_NO_PART) :
      (part_ok ? {dead_cnt_in, ready_cnt_in}
               : {`QUERY_NO_COUNT, `QUERY_NO_COUNT});

  // --------------------------------------------------------------------------
  // Read path fault check
  // --------------------------------------------------------------------------
  logic [PW-1:0] fix_data;
  logic          f_single;
  logic          f_double;

  phrase_fault_detect #(
    .DW         (PW)
  ) u_fault (
    .data_in    (rd_data_in),
    .check_in   (rd_check_in),
    .data_out   (fix_data),
    .single_out (f_single),
    .double_out (f_double)
  );

  wire       hit_single = rd_valid_in && f_single;
  wire       hit_double = rd_valid_in && f_double;
  wire       boot_fault = !init_r && reset_dfault_in;
  wire [3:0] flag_set   = {change_err_in, format_err_in,
                           hit_double || boot_fault, hit_single};
  wire [3:0] flag_clr   = wr_estat ? wb_dat_in[3:0] : 4'h0;

  // --------------------------------------------------------------------------
  // Bus response, registered one cycle after the strobe
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= acc;
      if (acc && !wb_we_in) begin
        dat_r <= rd_mux;
      end
    end
  end

  // Index and config, writable any time; index is not a locked field
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      param_idx_r <= 3'h0;
      err_cfg_r   <= 4'h0;
    end else begin
      if (wr_pidx) begin
        param_idx_r <= wb_dat_in[2:0];
      end
      if (wr_cfg) begin
        err_cfg_r <= wb_dat_in[3:0];
      end
    end
  end

  // Error flags: set wins over a same-cycle clear
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      err_flag_r <= 4'h0;
    end else begin
      err_flag_r <= (err_flag_r & ~flag_clr) | flag_set;
    end
  end

  // Interrupt: sticky flag gated by its own enable
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(err_flag_r & err_cfg_r);
    end
  end

  // Corrected read data, one cycle behind the raw phrase
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdv_r <= 1'b0;
      rdd_r <= '0;
    end else begin
      rdv_r <= rd_valid_in;
      if (rd_valid_in) begin
        rdd_r <= fix_data;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Parameter array; software locked out while a command runs
  // --------------------------------------------------------------------------
  for (genvar k = 0; k < 6; k++) begin : g_param
    wire sw_wr = wr_param && cmd_done_r && (param_idx_r == k);
    wire hw_wr = (state_r == nvm_cmd_pkg::ST_QUERY) && (qcnt_r == k);
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        param_mem[k] <= `PARAM_RESET;
      end else if (hw_wr) begin
        param_mem[k] <= q_val;
      end else if (sw_wr) begin
        if (wb_sel_in[1]) begin
          param_mem[k][15:8] <= wb_dat_in[15:8];
        end
        if (wb_sel_in[0]) begin
          param_mem[k][7:0] <= wb_dat_in[7:0];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status flags written by software
  // --------------------------------------------------------------------------
  wire acc_set = launch && reject;
  wire acc_clr = wr_stat && wb_dat_in[`STAT_ACC_ERR];
  wire pv_clr  = wr_stat && wb_dat_in[`STAT_PROT_VIOL];

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_err_r   <= 1'b0;
      prot_viol_r <= 1'b0;
    end else begin
      acc_err_r   <= acc_set || (acc_err_r && !acc_clr);
      prot_viol_r <= prot_viol_in || (prot_viol_r && !pv_clr);
    end
  end

  // Reset-sequence capture; verify bits read-only to software
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      init_r   <= 1'b0;
      verify_r <= 2'b00;
    end else begin
      init_r <= 1'b1;
      if (boot_fault) begin
        verify_r <= 2'b11;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------------
  // Done flag resets to one so the first launch is possible
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r    <= nvm_cmd_pkg::ST_IDLE;
      cmd_done_r <= 1'b1;
      cmd_r      <= 8'h00;
      qcnt_r     <= 3'h0;
    end else begin
      case (state_r)
        nvm_cmd_pkg::ST_IDLE: begin
          if (accept) begin
            cmd_done_r <= 1'b0;
            cmd_r      <= code;
            qcnt_r     <= `PIDX_USER_PART;
            if (code == `CMD_DISABLE_EMUL) begin
              state_r <= nvm_cmd_pkg::ST_HALT;
            end else begin
              state_r <= nvm_cmd_pkg::ST_QUERY;
            end
          end
        end
        nvm_cmd_pkg::ST_HALT: begin
          // Tag RAM and counter are left alone; engine only stops
          if (halt_ack_in) begin
            cmd_done_r <= 1'b1;
            state_r    <= nvm_cmd_pkg::ST_IDLE;
          end
        end
        nvm_cmd_pkg::ST_QUERY: begin
          // Done only in the edge that stores the last slot
          if (qcnt_r == `PIDX_SECTOR_CNT) begin
            cmd_done_r <= 1'b1;
            state_r    <= nvm_cmd_pkg::ST_IDLE;
          end else begin
            qcnt_r <= qcnt_r + 3'h1;
          end
        end
        default: begin
          state_r    <= nvm_cmd_pkg::ST_IDLE;
          cmd_done_r <= 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign wb_ack_out    = ack_r;
  assign wb_dat_out    = dat_r;
  assign halt_req_out  = (state_r == nvm_cmd_pkg::ST_HALT);
  assign cmd_code_out  = cmd_r;
  assign error_irq_out = irq_r;
  assign rd_valid_out  = rdv_r;
  assign rd_data_out   = rdd_r;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  chk_launch_clears: assert property (@(posedge clk_in) disable iff (!rstn_in)
    accept |=> !cmd_done_r && busy)
    else $error("accepted launch did not clear done flag");

  chk_reject_keeps: assert property (@(posedge clk_in) disable iff (!rstn_in)
    acc_set |=> acc_err_r && cmd_done_r && !busy)
    else $error("rejected launch started an operation");

  chk_index_err: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (launch && bad_idx) |=> acc_err_r)
    else $error("nonzero index at launch not flagged");

  chk_load_seq: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (launch && load_seq_in) |=> acc_err_r && cmd_done_r)
    else $error("launch during load sequence not flagged");

  chk_no_part: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (launch && no_part) |=> acc_err_r && $stable(verify_r) && $stable(prot_viol_r))
    else $error("disable without partition mishandled");

  chk_halt_done: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_r == nvm_cmd_pkg::ST_HALT && halt_ack_in) |=> cmd_done_r && !halt_req_out)
    else $error("halt acknowledge did not complete command");

  chk_query_fill: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (accept && code == `CMD_EMUL_QUERY && !partitioned_in) ##1
    (!partitioned_in)[*4] |=> cmd_done_r && param_mem[1] == 16'hffff &&
    param_mem[3] == 16'hffff && param_mem[4] == 16'h0000)
    else $error("unpartitioned query returned wrong values");

  chk_query_late: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (accept && code == `CMD_EMUL_QUERY) |=> !cmd_done_r [*4] ##1 cmd_done_r)
    else $error("query done flag timing wrong");

  chk_param_lock: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (wr_param && !cmd_done_r && param_idx_r == `PIDX_CMD) |=> $stable(param_mem[0]))
    else $error("parameter field changed while locked");

  chk_unimpl_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (acc && !wb_we_in && widx == `IDX_PARAM_WORD && !idx_impl) |=> wb_ack_out && wb_dat_out == 32'h0)
    else $error("unimplemented slot read not zero");

  chk_irq_gate: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ((err_flag_r[`ERR_CHANGE_STATE] && err_cfg_r[`ERR_CHANGE_STATE]) ||
     (err_flag_r[`ERR_SECTOR_FORMAT] && err_cfg_r[`ERR_SECTOR_FORMAT])) |=> error_irq_out)
    else $error("interrupt not gated by enables");

  chk_double_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
    hit_double |=> err_flag_r[`ERR_DOUBLE_FAULT] ##1 (error_irq_out == err_cfg_r[`ERR_DOUBLE_FAULT] || |err_flag_r[3:2] || err_flag_r[0]))
    else $error("double fault not recorded");

endmodule : nvm_cmd_launch

// ---- tb/nvm_cmd_launch_test.sv ----
// Self-checking bench for the flash command front end over its register bus
`timescale 1ns/1ps
`include "nvm_cmd_defines.svh"
module nvm_cmd_launch_test;
  localparam logic [7:0] A_IDX = {`IDX_PARAM_INDEX, 2'b00};
  localparam logic [7:0] A_CFG = {`IDX_ERR_CONFIG, 2'b00};
  localparam logic [7:0] A_ST  = {`IDX_FLASH_STATUS, 2'b00};
  localparam logic [7:0] A_EST = {`IDX_ERR_STATUS, 2'b00};
  localparam logic [7:0] A_PW  = {`IDX_PARAM_WORD, 2'b00};
  logic        clk_in = 0, rstn_in = 0, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0, load_seq_in = 0;
  logic        partitioned_in = 0, halt_ack_in = 0, change_err_in = 0, format_err_in = 0, prot_viol_in = 0;
  logic        reset_dfault_in = 0, rd_valid_in = 0, wb_ack_out, halt_req_out, rd_valid_out, error_irq_out;
  logic [7:0]  wb_adr_in = 8'h00, rd_check_in = 8'h00, dead_cnt_in = 8'h00, ready_cnt_in = 8'h00, cmd_code_out;
  logic [3:0]  wb_sel_in = 4'hf;
  logic [15:0] user_part_in = 16'h0000, buf_part_in = 16'h0000, erase_cnt_in = 16'h0000;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
  logic [63:0] rd_data_in = 64'h0, rd_data_out;
  int          n_errors = 0, comparisons = 0;
  logic [15:0] exp_q [4];

  nvm_cmd_launch dut_u (.clk_in, .rstn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .wb_dat_out, .wb_ack_out, .load_seq_in, .partitioned_in, .halt_req_out, .halt_ack_in,
    .user_part_in, .buf_part_in, .erase_cnt_in, .dead_cnt_in, .ready_cnt_in, .change_err_in,
    .format_err_in, .prot_viol_in, .reset_dfault_in, .rd_valid_in, .rd_data_in, .rd_check_in,
    .rd_valid_out, .rd_data_out, .cmd_code_out, .error_irq_out);

  // ---------------------------------------------------------------------------
  // Clock, bus tasks and comparison
  // ---------------------------------------------------------------------------
  always #2.5 clk_in = ~clk_in;

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One classic cycle; held until ack is sampled, then a gap cycle; only the watchdog ends a wait
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    wb_cyc_in <= 1'b1; wb_stb_in <= 1'b1; wb_we_in <= we; wb_adr_in <= a; wb_dat_in <= d;
    do begin
      @(posedge clk_in);
    end while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0; wb_stb_in <= 1'b0; wb_we_in <= 1'b0;
    @(posedge clk_in);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(what, {32'h0, exp}, {32'h0, q});
  endtask : rdc

  task automatic launch(input logic [7:0] code, input logic [2:0] idx);
    wr(A_IDX, 32'h0);
    wr(A_PW, {16'h0, code, 8'h00});
    wr(A_IDX, {29'h0, idx});
    wr(A_ST, 32'h80);
  endtask : launch

  // Poll done with a bounded count; a hang is a mismatch via the read
  task automatic wait_done;
    logic [31:0] q;
    for (int i = 0; i < 20; i++) begin
      wb(1'b0, A_ST, 32'h0, q);
      if (q[7] === 1'b1) break;
    end
  endtask : wait_done

  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk("error_irq", {63'h0, exp}, {63'h0, error_irq_out});
    @(posedge clk_in);
  endtask : chk_irq

  // Bit 0 single fault in data bit 0 of a zero phrase, bit 1 double fault in data bits 0 and 1
  task automatic fire(input int b);
    change_err_in <= (b == 3);
    format_err_in <= (b == 2);
    rd_valid_in   <= (b < 2);
    rd_data_in    <= (b == 1) ? 64'h3 : 64'h1;
    rd_check_in   <= 8'h00;
    @(posedge clk_in);
    change_err_in <= 1'b0;
    format_err_in <= 1'b0;
    rd_valid_in   <= 1'b0;
    @(negedge clk_in);
    chk("rd_valid", {63'h0, b < 2}, {63'h0, rd_valid_out});
    if (b == 0) chk("rd_data", 64'h0, rd_data_out);
    if (b == 1) chk("rd_data_raw", 64'h3, rd_data_out);
  endtask : fire

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    rdc(A_ST, 32'h80, "status_reset");
    wr(A_ST, 32'h4b);
    rdc(A_ST, 32'h80, "status_ro");
    prot_viol_in <= 1'b1;
    @(posedge clk_in);
    prot_viol_in <= 1'b0;
    @(posedge clk_in);
    rdc(A_ST, 32'h90, "status_prot");
    wr(A_ST, 32'h10);
    rdc(A_ST, 32'h80, "status_w1c");
    for (int s = 6; s < 8; s++) begin
      wr(A_IDX, s);
      wr(A_PW, 32'h1234);
      rdc(A_PW, 32'h0, "slot_unimpl");
    end
    rdc(8'h3c, 32'h0, "unmapped");
    $display("test registers done");
    // Partitioned here so that only the index can cause the refusal
    partitioned_in <= 1'b1;
    launch(`CMD_DISABLE_EMUL, 3'h1);
    rdc(A_ST, 32'ha0, "idx_reject");
    wr(A_ST, 32'h20);
    partitioned_in <= 1'b0;
    launch(`CMD_DISABLE_EMUL, 3'h0);
    rdc(A_ST, 32'ha0, "nopart_reject");
    wr(A_ST, 32'h20);
    load_seq_in <= 1'b1;
    launch(`CMD_EMUL_QUERY, 3'h0);
    rdc(A_ST, 32'ha0, "load_reject");
    wr(A_ST, 32'h20);
    load_seq_in <= 1'b0;
    launch(8'h20, 3'h0);
    rdc(A_ST, 32'ha0, "code_reject");
    wr(A_ST, 32'h20);
    chk("cmd_code_idle", 64'h0, {56'h0, cmd_code_out});
    $display("test rejects done");
    for (int p = 0; p < 2; p++) begin
      partitioned_in <= p[0];
      user_part_in   <= 16'h0012;
      buf_part_in    <= 16'h0003;
      erase_cnt_in   <= 16'h0456;
      dead_cnt_in    <= 8'h07;
      ready_cnt_in   <= 8'h09;
      if (p == 0) begin
        exp_q = '{16'hffff, 16'hffff, 16'hffff, 16'h0000};
      end else begin
        exp_q = '{16'h0012, 16'h0003, 16'h0456, 16'h0709};
      end
      launch(`CMD_EMUL_QUERY, 3'h0);
      wr(A_PW, 32'hbeef);
      wait_done();
      rdc(A_PW, 32'h1500, "slot0_locked");
      chk("cmd_code", 64'h15, {56'h0, cmd_code_out});
      for (int k = 1; k < 5; k++) begin
        wr(A_IDX, k);
        rdc(A_PW, {16'h0, exp_q[k-1]}, "query_slot");
      end
    end
    $display("test query done");
    launch(`CMD_DISABLE_EMUL, 3'h0);
    rdc(A_ST, 32'h08, "status_busy");
    chk("halt_req", 64'h1, {63'h0, halt_req_out});
    chk("cmd_code", 64'h14, {56'h0, cmd_code_out});
    halt_ack_in <= 1'b1;
    wait_done();
    halt_ack_in <= 1'b0;
    rdc(A_ST, 32'h80, "status_halted");
    chk("halt_req_idle", 64'h0, {63'h0, halt_req_out});
    $display("test disable done");
    for (int b = 0; b < 4; b++) begin
      wr(A_CFG, 32'h0);
      fire(b);
      chk_irq(1'b0);
      rdc(A_EST, 32'h1 << b, "error_status");
      wr(A_CFG, 32'h1 << b);
      chk_irq(1'b1);
      wr(A_EST, 32'h1 << b);
      chk_irq(1'b0);
    end
    $display("test interrupts done");
    rstn_in         <= 1'b0;
    reset_dfault_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    rdc(A_ST, 32'h83, "status_dfault");
    rdc(A_EST, 32'h2, "estat_dfault");
    $display("test reset fault done");
    final_report();
  end

  // Whole run is a few hundred cycles; this span leaves ample margin
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    final_report();
  end
endmodule : nvm_cmd_launch_test
